// File: include/osct_pkg.sv
// Purpose: constants for the oscillator mode and tuning block
// Assumes: apb with 32-bit data, one word per register
// Notes: mode codes and offsets are fixed here only
package osct_pkg;

    // register byte offsets
    localparam logic [7:0] OSCT_TRIM_OFS   = 8'h00;
    localparam logic [7:0] OSCT_CTRL_OFS   = 8'h04;
    localparam logic [7:0] OSCT_MODE_OFS   = 8'h08;
    localparam logic [7:0] OSCT_STAT_OFS   = 8'h0c;

    // internal_oscillator_trim fields
    localparam int OSCT_TRIM_LSB = 0;
    localparam int OSCT_TRIM_W   = 6;
    localparam int OSCT_MULT_BIT = 6;
    localparam int OSCT_LOSRC_BIT = 7;
    localparam logic [7:0] OSCT_TRIM_RST = 8'h00;

    // control fields: clock origin and internal frequency
    localparam int OSCT_ORG_LSB  = 0;
    localparam int OSCT_IFS_LSB  = 4;
    localparam logic [1:0] OSCT_ORG_RST = 2'h0;
    localparam logic [2:0] OSCT_IFS_RST = 3'h3;

    // mode field position and reset value
    localparam int OSCT_MODE_LSB = 0;
    localparam logic [3:0] OSCT_MODE_RST = 4'h9;

    // trim range marks
    localparam logic [5:0] OSCT_TRIM_MAX = 6'h1f;
    localparam logic [5:0] OSCT_TRIM_CAL = 6'h00;
    localparam logic [5:0] OSCT_TRIM_MIN = 6'h20;

    // start-up count in oscillator edges and quarter divide
    localparam logic [10:0] OSCT_START_EDGES = 11'h400;
    localparam logic [1:0]  OSCT_QDIV_HALF = 2'h1;
    localparam logic [2:0]  OSCT_MULT_RATIO = 3'h4;

    // gain and power levels
    localparam logic [1:0] OSCT_LVL_LOW  = 2'h0;
    localparam logic [1:0] OSCT_LVL_MED  = 2'h1;
    localparam logic [1:0] OSCT_LVL_HIGH = 2'h2;
    localparam logic [1:0] OSCT_LVL_MAX  = 2'h3;

    typedef enum logic [3:0] {
        low_gain_crystal_mode,
        medium_gain_crystal_mode,
        high_speed_crystal_high_power,
        high_speed_crystal_medium_power,
        ext_clock_high_power,
        ext_clock_medium_power,
        ext_clock_low_power,
        resistor_capacitor_quarter_clock_output_mode,
        resistor_capacitor_gpio_mode,
        int_osc_gpio_mode,
        int_osc_qclk_mode
    } osct_mode_t;

    typedef enum {
        osct_st_wait,
        osct_st_count,
        osct_st_run
    } osct_st_t;

endpackage : osct_pkg

// File: logic/osct_top.sv
// Purpose: oscillator mode select, start-up counter and trim
// Assumes: inputs synchronous to i_mclk; oscillators modelled
//          as sampled levels, analog parts outside
// Notes: registers over apb, zero wait states
// Function
// R1: external clock on pin one, pin two gpio
// R2: external clock low, medium, high power
// R3: external clock bypasses start-up counter
// R4: fully static, halted clock keeps state
// R5: crystal modes pick low, mid, high gain
// R6: high speed crystal medium or high power
// R7: rc clock-out mode: rc clock over four
// R8: rc gpio: pin one rc, pin two gpio
// R9: three internal oscillators, two trimmable
// R10: three-bit internal frequency select field
// R11: two-bit system clock origin select
// R12: two internal primary modes, pin two choice
// R13: internal primary modes release pin one
// R14: six-bit signed trim, resets to zero
// R15: 011111 max, 000000 cal, 100000 min
// R16: trim applies at once, no done flag
// R17: trim never touches low-frequency oscillator
// R18: origin bit picks divided or low osc
// R19: multiplier enable acts on every origin
// R20: multiplier gives four times its input
// R21: trim register full read/write, reset zero
//
// Implementation choices: the register addresses and the APB interface to the registers.
module osct_top
    import osct_pkg::*;
(
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // oscillator sources and events
    input  wire logic        i_pin1_in,
    input  wire logic        i_int_osc,
    input  wire logic        i_wake,
    // second oscillator pin
    output logic             o_pin2_out,
    output logic             o_pin2_oe,
    output logic             o_pin2_gpio,
    // first oscillator pin
    output logic             o_pin1_gpio,
    output logic             o_pin1_clk,
    // oscillator controls
    output logic      [1:0]  o_amp_gain,
    output logic      [1:0]  o_ext_power,
    output logic      [5:0]  o_hf_trim,
    output logic      [5:0]  o_mf_trim,
    output logic             o_low_from_div,
    output logic             o_mult_en,
    output logic      [2:0]  o_mult_ratio,
    output logic      [2:0]  o_int_freq_sel,
    output logic      [1:0]  o_clk_origin,
    output logic             o_exec_ready
);

    logic        rst_s1_reg;
    logic        rst_n;
    logic [7:0]  trim_reg;
    logic [1:0]  org_reg;
    logic [2:0]  ifs_reg;
    osct_mode_t  mode_reg;
    osct_st_t    st_reg;
    osct_st_t    st_next;
    logic [10:0] start_cnt_reg;
    logic        pin1_d_reg;
    logic        int_d_reg;
    logic [1:0]  q_cnt_reg;
    logic        q_out_reg;
    logic        wr_en;
    logic        rd_en;
    logic        mapped;
    logic        is_xtal;
    logic        is_ext;
    logic        is_int;
    logic        is_qclk_out;
    logic        src_lvl;
    logic        src_d;
    logic        src_rise;
    logic        pin1_rise;

    // reset release through two flops
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // apb decode; zero wait states
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !pwrite;
    always_comb begin
        mapped = (paddr == OSCT_TRIM_OFS) || (paddr == OSCT_CTRL_OFS)
              || (paddr == OSCT_MODE_OFS) || (paddr == OSCT_STAT_OFS);
    end
    assign pslverr = psel && penable && !mapped;

    // trim register, all eight bits writable
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            trim_reg <= OSCT_TRIM_RST; // R14 R21
        end else if (wr_en && paddr == OSCT_TRIM_OFS) begin
            trim_reg <= pwdata[7:0]; // R21
        end
    end

    // control register: origin and internal frequency
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            org_reg <= OSCT_ORG_RST;
            ifs_reg <= OSCT_IFS_RST;
        end else if (wr_en && paddr == OSCT_CTRL_OFS) begin
            org_reg <= pwdata[OSCT_ORG_LSB +: 2]; // R11
            ifs_reg <= pwdata[OSCT_IFS_LSB +: 3]; // R10
        end
    end

    // mode register; unknown codes fall back to internal gpio mode
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= osct_mode_t'(OSCT_MODE_RST);
        end else if (wr_en && paddr == OSCT_MODE_OFS) begin
            if (pwdata[OSCT_MODE_LSB +: 4] > 4'(int_osc_qclk_mode)) begin
                mode_reg <= int_osc_gpio_mode;
            end else begin
                mode_reg <= osct_mode_t'(pwdata[OSCT_MODE_LSB +: 4]);
            end
        end
    end

    // read mux; data from flops
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            case (paddr)
                OSCT_TRIM_OFS: prdata <= {24'h00_0000, trim_reg}; // R21
                OSCT_CTRL_OFS: prdata <= {25'h000_0000, ifs_reg, 2'h0, org_reg};
                OSCT_MODE_OFS: prdata <= {28'h000_0000, mode_reg};
                OSCT_STAT_OFS: prdata <= {29'h0000_0000, q_out_reg,
                                          st_reg == osct_st_count, o_exec_ready};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // mode classes
    always_comb begin
        is_xtal = (mode_reg == low_gain_crystal_mode)
               || (mode_reg == medium_gain_crystal_mode)
               || (mode_reg == high_speed_crystal_high_power)
               || (mode_reg == high_speed_crystal_medium_power);
        is_ext  = (mode_reg == ext_clock_high_power)
               || (mode_reg == ext_clock_medium_power)
               || (mode_reg == ext_clock_low_power);
        is_int  = (mode_reg == int_osc_gpio_mode)
               || (mode_reg == int_osc_qclk_mode);
        is_qclk_out = (mode_reg == resistor_capacitor_quarter_clock_output_mode)
                   || (mode_reg == int_osc_qclk_mode);
    end

    // amplifier gain and external clock power level
    always_comb begin
        o_amp_gain  = OSCT_LVL_LOW;
        o_ext_power = OSCT_LVL_LOW;
        case (mode_reg)
            low_gain_crystal_mode:    o_amp_gain  = OSCT_LVL_LOW; // R5
            medium_gain_crystal_mode: o_amp_gain  = OSCT_LVL_MED; // R5
            high_speed_crystal_medium_power: o_amp_gain = OSCT_LVL_HIGH; // R5 R6
            high_speed_crystal_high_power:   o_amp_gain = OSCT_LVL_MAX; // R6
            ext_clock_low_power:      o_ext_power = OSCT_LVL_LOW; // R2
            ext_clock_medium_power:   o_ext_power = OSCT_LVL_MED; // R2
            ext_clock_high_power:     o_ext_power = OSCT_LVL_HIGH; // R2
            default: begin
                o_amp_gain  = OSCT_LVL_LOW;
                o_ext_power = OSCT_LVL_LOW;
            end
        endcase
    end

    // pin one: clock input unless an internal primary mode
    assign o_pin1_gpio = is_int; // R13
    assign o_pin1_clk  = is_ext || is_xtal || !is_int; // R1 R8

    // pin two: driven only in the two clock-out modes
    assign o_pin2_oe   = is_qclk_out; // R7 R12
    assign o_pin2_gpio = is_ext
                      || (mode_reg == resistor_capacitor_gpio_mode)
                      || (mode_reg == int_osc_gpio_mode); // R1 R8 R12
    assign o_pin2_out  = is_qclk_out && q_out_reg;

    // edge detect of the active primary oscillator
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin1_d_reg <= 1'b0;
            int_d_reg  <= 1'b0;
        end else begin
            pin1_d_reg <= i_pin1_in;
            int_d_reg  <= i_int_osc;
        end
    end
    assign src_lvl   = is_int ? i_int_osc : i_pin1_in;
    assign src_d     = is_int ? int_d_reg : pin1_d_reg;
    assign src_rise  = src_lvl && !src_d;
    assign pin1_rise = i_pin1_in && !pin1_d_reg;

    // quarter clock: toggle every second source edge
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            q_cnt_reg <= 2'h0;
            q_out_reg <= 1'b0;
        end else if (src_rise) begin
            if (q_cnt_reg == OSCT_QDIV_HALF) begin
                q_cnt_reg <= 2'h0;
                q_out_reg <= !q_out_reg; // R7 R12
            end else begin
                q_cnt_reg <= q_cnt_reg + 2'h1;
            end
        end
    end

    // start-up: counts oscillator edges, not time, so a stopped
    // clock only stalls it and nothing is lost
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            osct_st_wait: begin
                st_next = is_xtal ? osct_st_count : osct_st_run; // R3
            end
            osct_st_count: begin
                if (!is_xtal) begin
                    st_next = osct_st_run; // R3
                end else if (pin1_rise && start_cnt_reg == OSCT_START_EDGES - 11'h1) begin
                    st_next = osct_st_run;
                end
            end
            osct_st_run: begin
                if (i_wake) begin
                    st_next = osct_st_wait;
                end
            end
            default: st_next = osct_st_wait;
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= osct_st_wait;
        end else begin
            st_reg <= st_next; // R4
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            start_cnt_reg <= 11'h000;
        end else if (st_reg != osct_st_count) begin
            start_cnt_reg <= 11'h000;
        end else if (pin1_rise) begin
            start_cnt_reg <= start_cnt_reg + 11'h1;
        end
    end

    assign o_exec_ready = (st_reg == osct_st_run);

    // trim feeds only the high and medium oscillators
    assign o_hf_trim      = trim_reg[OSCT_TRIM_LSB +: OSCT_TRIM_W]; // R9 R15 R16
    assign o_mf_trim      = trim_reg[OSCT_TRIM_LSB +: OSCT_TRIM_W]; // R9 R17
    assign o_low_from_div = trim_reg[OSCT_LOSRC_BIT]; // R18
    // multiplier bit is honoured in every primary mode
    assign o_mult_en      = trim_reg[OSCT_MULT_BIT]; // R19
    assign o_mult_ratio   = o_mult_en ? OSCT_MULT_RATIO : 3'h1; // R20
    assign o_int_freq_sel = ifs_reg; // R10
    assign o_clk_origin   = org_reg; // R11

    // checks
    chk_trim_write: assert property (@(posedge i_mclk) disable iff (!rst_n) // R16
        wr_en && paddr == OSCT_TRIM_OFS |=> o_hf_trim == $past(pwdata[5:0])
            && o_mult_en == $past(pwdata[6]))
        else $error("trim write not applied next cycle");

    chk_low_untrimmed: assert property (@(posedge i_mclk) disable iff (!rst_n) // R18
        !(wr_en && paddr == OSCT_TRIM_OFS) |=> $stable({o_low_from_div, o_mult_en, o_hf_trim, o_mf_trim}))
        else $error("low origin or trim changed without a write");

    chk_ext_no_delay: assert property (@(posedge i_mclk) disable iff (!rst_n) // R3
        (is_ext && st_reg == osct_st_wait) |=> ##[0:1] o_exec_ready)
        else $error("external clock mode delayed start");

    chk_xtal_wait: assert property (@(posedge i_mclk) disable iff (!rst_n) // R3
        is_xtal && $rose(o_exec_ready) |-> $past(start_cnt_reg) == OSCT_START_EDGES - 11'h1)
        else $error("crystal start before edge count");

    chk_pin2_gpio_mode: assert property (@(posedge i_mclk) disable iff (!rst_n) // R1
        (is_ext || mode_reg == resistor_capacitor_gpio_mode) |-> !o_pin2_oe && o_pin2_gpio)
        else $error("pin two driven in gpio mode");

    chk_int_pin1: assert property (@(posedge i_mclk) disable iff (!rst_n) // R13
        is_int |-> o_pin1_gpio && !o_pin1_clk)
        else $error("pin one not released in internal mode");

    chk_quarter_rate: assert property (@(posedge i_mclk) disable iff (!rst_n) // R7
        $changed(q_out_reg) |-> $past(src_rise) && $past(q_cnt_reg) == 2'h1)
        else $error("quarter clock toggled off its edge");

    chk_gain_level: assert property (@(posedge i_mclk) disable iff (!rst_n) // R6
        mode_reg == high_speed_crystal_high_power |-> o_amp_gain == OSCT_LVL_MAX)
        else $error("high power crystal gain wrong");

    chk_unmapped_err: assert property (@(posedge i_mclk) disable iff (!rst_n)
        psel && penable && paddr > 8'h0c |-> pslverr)
        else $error("unmapped access without error");

    // per-mode spot checks; one mode each, two clock-out modes for chk_qclk_pin, keeps them cheap to evaluate
    chk_ext_power: assert property (@(posedge i_mclk) disable iff (!rst_n) // R2
        mode_reg == ext_clock_high_power |-> o_ext_power == OSCT_LVL_HIGH && o_amp_gain == OSCT_LVL_LOW)
        else $error("high power external clock level wrong");

    chk_xtal_gain: assert property (@(posedge i_mclk) disable iff (!rst_n) // R5
        mode_reg == medium_gain_crystal_mode |-> o_amp_gain == OSCT_LVL_MED && o_ext_power == OSCT_LVL_LOW)
        else $error("medium crystal gain wrong");

    chk_rc_pins: assert property (@(posedge i_mclk) disable iff (!rst_n) // R8
        mode_reg == resistor_capacitor_gpio_mode |-> o_pin1_clk && !o_pin1_gpio && o_pin2_gpio)
        else $error("rc gpio pin use wrong");

    chk_qclk_pin: assert property (@(posedge i_mclk) disable iff (!rst_n) // R12
        is_qclk_out |-> o_pin2_oe && !o_pin2_gpio && o_pin2_out == q_out_reg)
        else $error("pin two not carrying quarter clock");

    // register path: a lost write would only show up as a wrong clock later
    chk_ctrl_write: assert property (@(posedge i_mclk) disable iff (!rst_n) // R10
        wr_en && paddr == OSCT_CTRL_OFS |=> o_int_freq_sel == $past(pwdata[6:4])
            && o_clk_origin == $past(pwdata[1:0]))
        else $error("control write not applied next cycle");

    chk_trim_read: assert property (@(posedge i_mclk) disable iff (!rst_n) // R21
        rd_en && !penable && paddr == OSCT_TRIM_OFS |=> prdata == {24'h00_0000, $past(trim_reg)})
        else $error("trim read data wrong");

    chk_reset_vals: assert property (@(posedge i_mclk) disable iff (!rst_n) // R14
        $rose(rst_n) |-> trim_reg == OSCT_TRIM_RST && o_exec_ready == 1'b0)
        else $error("trim not cleared by reset");

    // start-up: wake must restart it, and a halted pin must freeze the count, never reset it
    chk_wake_restart: assert property (@(posedge i_mclk) disable iff (!rst_n) // R3
        o_exec_ready && i_wake |=> !o_exec_ready)
        else $error("wake did not restart start-up");

    chk_count_hold: assert property (@(posedge i_mclk) disable iff (!rst_n) // R4
        st_reg == osct_st_count && is_xtal && !pin1_rise |=> $stable(start_cnt_reg))
        else $error("start-up count moved without a pin edge");

    cov_ext_mode:  cover property (@(posedge i_mclk) is_ext && o_exec_ready);
    cov_xtal_done: cover property (@(posedge i_mclk) is_xtal && $rose(o_exec_ready));
    cov_qclk_out:  cover property (@(posedge i_mclk) is_qclk_out && $rose(o_pin2_out));
    cov_mult_on:   cover property (@(posedge i_mclk) $rose(o_mult_en));
    cov_trim_min:  cover property (@(posedge i_mclk) o_hf_trim == OSCT_TRIM_MIN);

endmodule : osct_top

// File: verif/osct_src_model.sv
// Purpose: far-side source on the first oscillator pin
// Assumes: crystal, rc network or external clock seen as a level
// Notes: a halted source stands still low, it never floats
module osct_src_model (
    // control
    input  wire logic       i_mclk,
    input  wire logic       i_run,
    input  wire logic [7:0] i_half,
    // pin level
    output logic            o_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_reg;
    initial begin
        o_pin = 1'b0;
        cnt_reg = 8'h00;
    end
    always @(posedge i_mclk) begin
        if (!i_run) begin
            o_pin <= 1'b0;
            cnt_reg <= 8'h00;
        end else if (cnt_reg + 8'h01 >= i_half) begin
            o_pin <= ~o_pin;
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule : osct_src_model

// File: verif/test_oscillator_source_mode_and_tuning.sv
// Purpose: self-checking bench for the oscillator mode and trim block
// Assumes: zero-wait apb, source pin halves every 2 clocks
// Notes: apb answers are queued and judged by a separate monitor
module test_oscillator_source_mode_and_tuning
    import osct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_mclk, i_rst_n, psel, penable, pwrite, i_int_osc, i_wake, run, pin1;
    logic [7:0]  paddr, tv, msk;
    logic [31:0] pwdata, prdata, v;
    logic        pready, pslverr, o_pin2_out, o_pin2_oe, o_pin2_gpio, o_pin1_gpio, o_pin1_clk;
    logic        o_low_from_div, o_mult_en, o_exec_ready, src_prev, q_prev, qc_on, qc_seen;
    logic [1:0]  o_amp_gain, o_ext_power, o_clk_origin, io_cnt;
    logic [5:0]  o_hf_trim, o_mf_trim;
    logic [2:0]  o_mult_ratio, o_int_freq_sel;
    logic [32:0] exp_q[$];
    int          failures, checks, rises, n, me, cur_mode;

    osct_top osct_top_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_pin1_in(pin1), .i_int_osc(i_int_osc), .i_wake(i_wake),
        .o_pin2_out(o_pin2_out), .o_pin2_oe(o_pin2_oe), .o_pin2_gpio(o_pin2_gpio),
        .o_pin1_gpio(o_pin1_gpio), .o_pin1_clk(o_pin1_clk), .o_amp_gain(o_amp_gain),
        .o_ext_power(o_ext_power), .o_hf_trim(o_hf_trim), .o_mf_trim(o_mf_trim),
        .o_low_from_div(o_low_from_div), .o_mult_en(o_mult_en), .o_mult_ratio(o_mult_ratio),
        .o_int_freq_sel(o_int_freq_sel), .o_clk_origin(o_clk_origin), .o_exec_ready(o_exec_ready));
    osct_src_model osct_src_model_i (.i_mclk(i_mclk), .i_run(run), .i_half(8'h02), .o_pin(pin1));

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // request is held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int k;
        k = 0;
        exp_q.push_back(e);
        @(posedge i_mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        forever begin
            @(posedge i_mclk);
            if (pready === 1'b1) break;
            k++;
            if (k > 20) begin
                chk("pready", 33'h1, 33'h0);
                tally_and_finish();
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wake_and_wait(output int c);
        @(posedge i_mclk);
        i_wake <= 1'b1;
        @(posedge i_mclk);
        i_wake <= 1'b0;
        c = 0;
        do begin
            @(posedge i_mclk);
            c++;
        end while (o_exec_ready !== 1'b1 && c < 7000);
        if (c >= 7000) begin
            chk("start-up wait", 33'h1, 33'h0);
            tally_and_finish();
        end
    endtask : wake_and_wait

    function automatic logic [7:0] mode_exp(input int m);
        logic [1:0] g, e;
        g = (m == 1) ? 2'h1 : (m == 2) ? 2'h3 : (m == 3) ? 2'h2 : 2'h0;
        e = (m == 4) ? 2'h2 : (m == 5) ? 2'h1 : 2'h0;
        return {m < 9, m == 7 || m == 10, m > 3 && m != 7 && m != 10, m > 8, e, g};
    endfunction : mode_exp

    // internal oscillator stand-in: rises every 8 clocks
    always @(posedge i_mclk) begin
        io_cnt <= io_cnt + 2'h1;
        if (io_cnt == 2'h3) i_int_osc <= ~i_int_osc;
    end

    // monitor: apb answers, and source rises per quarter clock period
    always @(posedge i_mclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) chk("apb queue", 33'h1, 33'h0);
            else chk("apb answer", exp_q.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
        end
        if (((cur_mode == 10) ? i_int_osc : pin1) && !src_prev) rises++;
        if (!qc_on) qc_seen = 1'b0;
        if (o_pin2_out && !q_prev) begin
            if (qc_on && qc_seen) chk("quarter clock", 33'd4, 33'(rises));
            qc_seen = qc_on;
            rises = 0;
        end
        src_prev = (cur_mode == 10) ? i_int_osc : pin1;
        q_prev = o_pin2_out;
    end

    initial begin
        {psel, penable, pwrite, i_wake, i_int_osc, qc_on, qc_seen, src_prev, q_prev} = '0;
        {paddr, pwdata, io_cnt, failures, checks, rises, cur_mode} = '0;
        run = 1'b1;
        i_rst_n = 1'b0;
        void'($urandom(19629));
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
        apb(0, OSCT_TRIM_OFS, 0, 33'h0);
        apb(0, OSCT_CTRL_OFS, 0, 33'({OSCT_IFS_RST, 2'h0, OSCT_ORG_RST}));
        apb(0, OSCT_MODE_OFS, 0, 33'(OSCT_MODE_RST));
        for (int i = 0; i < 8; i++) begin
            tv = (i == 0) ? 8'h1f : (i == 1) ? 8'h20 : (i == 2) ? 8'h00 : 8'($urandom);
            apb(1, OSCT_TRIM_OFS, {24'h0, tv}, 33'h0);
            apb(0, OSCT_TRIM_OFS, 0, {25'h0, tv});
            chk("trim outputs", 33'({tv[7:6], tv[6] ? OSCT_MULT_RATIO : 3'h1, tv[5:0], tv[5:0]}),
                33'({o_low_from_div, o_mult_en, o_mult_ratio, o_hf_trim, o_mf_trim}));
            v = $urandom;
            apb(1, OSCT_CTRL_OFS, v, 33'h0);
            apb(0, OSCT_CTRL_OFS, 0, {1'b0, v & 32'h73});
            chk("ctrl outputs", 33'({v[6:4], v[1:0]}), 33'({o_int_freq_sel, o_clk_origin}));
        end
        apb(1, 8'h10, 32'hff, {1'b1, 32'h0});
        apb(0, 8'h84, 0, {1'b1, 32'h0});
        apb(1, OSCT_STAT_OFS, 32'hff, 33'h0);
        apb(1, OSCT_TRIM_OFS, 32'h40, 33'h0);
        for (int m = 0; m < 12; m++) begin
            me = (m == 11) ? 9 : m;
            apb(1, OSCT_MODE_OFS, (m == 11) ? 32'hf : 32'(m), 33'h0);
            apb(0, OSCT_MODE_OFS, 0, 33'(me));
            msk = 8'hff;
            chk("mode decode", {24'h1, mode_exp(me) & msk}, {24'(o_mult_en), msk &
                {o_pin1_clk, o_pin2_oe, o_pin2_gpio, o_pin1_gpio, o_ext_power, o_amp_gain}});
        end
        cur_mode = 7;
        apb(1, OSCT_MODE_OFS, 32'h7, 33'h0);
        repeat (2) @(posedge i_mclk);
        qc_on = 1'b1;
        repeat (80) @(posedge i_mclk);
        qc_on = 1'b0;
        cur_mode = 10;
        apb(1, OSCT_MODE_OFS, 32'ha, 33'h0);
        repeat (2) @(posedge i_mclk);
        qc_on = 1'b1;
        repeat (150) @(posedge i_mclk);
        qc_on = 1'b0;
        apb(1, OSCT_MODE_OFS, 32'h6, 33'h0);
        wake_and_wait(n);
        chk("ext clock start", 33'h1, 33'(n <= 4));
        // crystal start with the source halted for 1000 clocks midway
        apb(1, OSCT_MODE_OFS, 32'h0, 33'h0);
        fork
            wake_and_wait(n);
            begin
                repeat (1500) @(posedge i_mclk);
                run <= 1'b0;
                repeat (1000) @(posedge i_mclk);
                run <= 1'b1;
            end
        join
        chk("crystal start", 33'h1, 33'(n >= 5085 && n <= 5115));
        apb(0, OSCT_TRIM_OFS, 0, 33'h40);
        tally_and_finish();
    end
endmodule : test_oscillator_source_mode_and_tuning
